/* File: core/gih_pkg.sv */
/*
 * Shared constants and types for the gauge serial-bus host controller.
 * Assumes a 40 MHz core clock; every cycle count below is derived from it.
 */
package gih_pkg;

	// ========================================================================
	// Core clock
	localparam int CLK_NS  = 25;
	localparam int CLK_KHZ = 40000;

	// Rounds a least time in nanoseconds up to whole clock cycles.
	function automatic int ns2cyc(input int ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction : ns2cyc

	// Picks the larger of two counts.
	function automatic int maxi(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : maxi

	// ========================================================================
	// Target addressing
	localparam logic [6:0] TARGET_ADDR = 7'h55;
	localparam logic [7:0] ADDR_WR     = {TARGET_ADDR, 1'b0};
	localparam logic [7:0] ADDR_RD     = {TARGET_ADDR, 1'b1};

	// ========================================================================
	// Serial clock phases, standard and fast rate
	localparam int STD_RATE_KHZ  = 100;
	localparam int FAST_RATE_KHZ = 400;
	localparam int STD_LOW_NS    = 4700;
	localparam int STD_HIGH_NS   = 4000;
	localparam int FAST_LOW_NS   = 1300;
	localparam int FAST_HIGH_NS  = 600;
	localparam logic [17:0] STD_LOW_CYC  =
		18'(maxi(ns2cyc(STD_LOW_NS), CLK_KHZ / (2 * STD_RATE_KHZ)));
	localparam logic [17:0] STD_HIGH_CYC =
		18'(maxi(ns2cyc(STD_HIGH_NS), CLK_KHZ / (2 * STD_RATE_KHZ)));
	localparam logic [17:0] FAST_LOW_CYC =
		18'(maxi(ns2cyc(FAST_LOW_NS), CLK_KHZ / (2 * FAST_RATE_KHZ)));
	localparam logic [17:0] FAST_HIGH_CYC =
		18'(maxi(ns2cyc(FAST_HIGH_NS), CLK_KHZ / (2 * FAST_RATE_KHZ)));

	// ========================================================================
	// Gaps and waits
	localparam int          TBUF_US         = 66;
	localparam logic [11:0] TBUF_CYC        = 12'(ns2cyc(TBUF_US * 1000));
	localparam int          STRETCH_MS      = 4;
	localparam int          STRETCH_CYC_DEF = STRETCH_MS * CLK_KHZ;
	localparam int          PACE_MS         = 500;
	localparam int          PACE_CYC_DEF    = PACE_MS * CLK_KHZ;
	localparam int          SETTLE_MS       = 2000;
	localparam int          SETTLE_CYC_DEF  = SETTLE_MS * CLK_KHZ;

	// ========================================================================
	// Byte engine operations
	typedef enum logic [3:0] {
		OP_START = 4'h1,
		OP_STOP  = 4'h2,
		OP_WR    = 4'h4,
		OP_RD    = 4'h8
	} gih_op_t;

endpackage : gih_pkg

/* File: core/gih_byte_if.sv */
/*
 * Link between the host sequencer and its byte engine.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface gih_byte_if import gih_pkg::*; ();
	logic       req;
	gih_op_t    op;
	logic [7:0] wdata;
	logic       ack_out;
	logic       fast;
	logic       scl_s;
	logic       sda_s;
	logic       done;
	logic [7:0] rdata;
	logic       ack_in;
	logic       tmo;
	logic       scl_oe;
	logic       sda_oe;

	modport ctl (output req, op, wdata, ack_out, fast, scl_s, sda_s,
		input done, rdata, ack_in, tmo, scl_oe, sda_oe);
	modport eng (input req, op, wdata, ack_out, fast, scl_s, sda_s,
		output done, rdata, ack_in, tmo, scl_oe, sda_oe);
endinterface : gih_byte_if

`default_nettype wire

/* File: core/gih_byte_engine.sv */
/*
 * Bit-level engine: start, stop, byte write and byte read on the serial pins.
 * Assumes synchronised pin levels and a single request held until taken in idle.
 */
`timescale 1ns/10ps
`default_nettype none

module gih_byte_engine import gih_pkg::*; #(
	parameter int STRETCH_CYC = STRETCH_CYC_DEF
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Sequencer side
	gih_byte_if.eng   bi
);

	typedef enum logic [4:0] {
		E_IDLE = 5'b00001,
		E_LOW  = 5'b00010,
		E_RISE = 5'b00100,
		E_HIGH = 5'b01000,
		E_HOLD = 5'b10000
	} gih_eng_t;

	gih_eng_t    st_reg;
	gih_op_t     op_reg;
	logic [8:0]  tx_reg;
	logic [8:0]  rx_reg;
	logic [3:0]  nbit_reg;
	logic [17:0] cnt_reg;
	logic        scl_oe_reg;
	logic        sda_oe_reg;
	logic        done_reg;
	logic        tmo_reg;

	// ========================================================================
	// Phase limits and the shift word that a request loads.
	wire logic [17:0] low_lim   = bi.fast ? FAST_LOW_CYC : STD_LOW_CYC;
	wire logic [17:0] high_lim  = bi.fast ? FAST_HIGH_CYC : STD_HIGH_CYC;
	wire logic        low_mid   = (cnt_reg == (low_lim >> 1));
	wire logic        low_end   = (cnt_reg == low_lim - 18'd1);
	wire logic        high_end  = (cnt_reg == high_lim - 18'd1);
	wire logic        str_end   = (cnt_reg == 18'(STRETCH_CYC - 1));
	wire logic        is_byte   = (bi.op == OP_WR) || (bi.op == OP_RD);
	wire logic [8:0]  tx_load   = (bi.op == OP_WR) ? {bi.wdata, 1'b1} :
		(bi.op == OP_RD) ? {8'hff, ~bi.ack_out} :
		(bi.op == OP_START) ? 9'h100 : 9'h000;

	assign bi.scl_oe = scl_oe_reg;
	assign bi.sda_oe = sda_oe_reg;
	assign bi.done   = done_reg;
	assign bi.tmo    = tmo_reg;
	assign bi.rdata  = rx_reg[8:1];
	assign bi.ack_in = ~rx_reg[0];

	// ========================================================================
	// Bit sequencer: low phase, wait for release, high phase.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg     <= E_IDLE;
			op_reg     <= OP_STOP;
			tx_reg     <= 9'h000;
			rx_reg     <= 9'h000;
			nbit_reg   <= 4'h0;
			cnt_reg    <= 18'h00000;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			done_reg   <= 1'b0;
			tmo_reg    <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			tmo_reg  <= 1'b0;
			case (st_reg)
				E_IDLE: if (bi.req) begin
					op_reg   <= bi.op;
					tx_reg   <= tx_load;
					nbit_reg <= is_byte ? 4'h9 : 4'h1;
					cnt_reg  <= 18'h00000;
					st_reg   <= scl_oe_reg ? E_LOW : E_RISE;
				end
				E_LOW: begin
					cnt_reg <= cnt_reg + 18'd1;
					if (low_mid) sda_oe_reg <= ~tx_reg[8];
					if (low_end) begin
						scl_oe_reg <= 1'b0;
						cnt_reg    <= 18'h00000;
						st_reg     <= E_RISE;
					end
				end
				E_RISE: if (bi.scl_s) begin
					rx_reg  <= {rx_reg[7:0], bi.sda_s};
					cnt_reg <= 18'h00000;
					st_reg  <= E_HIGH;
				end else if (str_end) begin
					scl_oe_reg <= 1'b0;
					sda_oe_reg <= 1'b0;
					tmo_reg    <= 1'b1;
					done_reg   <= 1'b1;
					st_reg     <= E_IDLE;
				end else begin
					cnt_reg <= cnt_reg + 18'd1;
				end
				E_HIGH: begin
					cnt_reg <= cnt_reg + 18'd1;
					if (high_end) begin
						cnt_reg <= 18'h00000;
						if (op_reg == OP_START) begin
							sda_oe_reg <= 1'b1;
							st_reg     <= E_HOLD;
						end else if (op_reg == OP_STOP) begin
							sda_oe_reg <= 1'b0;
							done_reg   <= 1'b1;
							st_reg     <= E_IDLE;
						end else begin
							scl_oe_reg <= 1'b1;
							tx_reg     <= {tx_reg[7:0], 1'b0};
							nbit_reg   <= nbit_reg - 4'd1;
							done_reg   <= (nbit_reg == 4'd1);
							st_reg     <= (nbit_reg == 4'd1) ? E_IDLE : E_LOW;
						end
					end
				end
				E_HOLD: begin
					cnt_reg <= cnt_reg + 18'd1;
					if (high_end) begin
						scl_oe_reg <= 1'b1;
						done_reg   <= 1'b1;
						st_reg     <= E_IDLE;
					end
				end
				default: st_reg <= E_IDLE;
			endcase
		end
	end

endmodule : gih_byte_engine

`default_nettype wire

/* File: core/gih_host.sv */
/*
 * Host controller that reads and writes command locations of a fuel gauge
 * over its two-wire serial bus, generating the serial clock itself.
 * Assumes open-drain pins with pull-ups outside and a 40 MHz core clock.
 */
`timescale 1ns/10ps
`default_nettype none

module gih_host import gih_pkg::*; #(
	parameter int STRETCH_CYC = STRETCH_CYC_DEF,
	parameter int PACE_CYC    = PACE_CYC_DEF,
	parameter int SETTLE_CYC  = SETTLE_CYC_DEF
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Command request
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic       cmd_read,
	input  wire logic       cmd_quick,
	input  wire logic [7:0] cmd_loc,
	input  wire logic [3:0] cmd_len,
	input  wire logic       fast_mode,
	// Write data stream
	input  wire logic       wr_valid,
	output logic            wr_ready,
	input  wire logic [7:0] wr_data,
	// Read data and status
	output logic            rd_valid,
	output logic [7:0]      rd_data,
	output logic            done,
	output logic            nack_err,
	output logic            tmo_err,
	output logic            busy,
	// Serial bus pins
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe
);

	typedef enum logic [8:0] {
		M_IDLE   = 9'h001,
		M_GAP    = 9'h002,
		M_START  = 9'h004,
		M_ADDR   = 9'h008,
		M_CMD    = 9'h010,
		M_RSTART = 9'h020,
		M_RADDR  = 9'h040,
		M_DATA   = 9'h080,
		M_STOP   = 9'h100
	} gih_main_t;

	gih_main_t   st_reg;
	logic        issued_reg;
	logic        read_reg;
	logic        quick_reg;
	logic        fast_reg;
	logic        split_reg;
	logic        err_reg;
	logic        last_wr_reg;
	logic [7:0]  loc_reg;
	logic [3:0]  left_reg;
	logic [11:0] gap_reg;
	logic [26:0] since_reg;
	logic        rd_valid_reg;
	logic [7:0]  rd_data_reg;
	logic        done_reg;
	logic        nack_reg;
	logic        tmo_reg;
	logic        scl_m_reg;
	logic        scl_s_reg;
	logic        sda_m_reg;
	logic        sda_s_reg;

	gih_byte_if bi ();

	gih_byte_engine #(
		.STRETCH_CYC (STRETCH_CYC)
	) u_engine (
		.core_clk (core_clk),
		.rst      (rst),
		.bi       (bi.eng)
	);

	// ========================================================================
	// Pin synchronisers; the first stage feeds only the second.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
		end else begin
			scl_m_reg <= scl_i;
			scl_s_reg <= scl_m_reg;
			sda_m_reg <= sda_i;
			sda_s_reg <= sda_m_reg;
		end
	end

	// ========================================================================
	// Spacing gates between packets and between commands.
	wire logic gap_done  = (gap_reg >= TBUF_CYC);
	wire logic pace_done = (since_reg >= 27'(PACE_CYC));
	wire logic settled   = (since_reg >= 27'(SETTLE_CYC));
	wire logic gate_ok   = gap_done && pace_done && !(last_wr_reg && cmd_read && !settled);
	wire logic op_state  = (st_reg != M_IDLE) && (st_reg != M_GAP);
	wire logic data_wr   = (st_reg == M_DATA) && !read_reg;
	wire logic last_byte = (left_reg == 4'd1);

	// Request and data selection toward the byte engine.
	// Serial-only gauge access.
	assign cmd_ready  = (st_reg == M_IDLE) && gate_ok;
	assign wr_ready   = data_wr && !issued_reg;
	assign bi.req     = op_state && !issued_reg && (!data_wr || wr_valid);
	assign bi.op      = ((st_reg == M_START) || (st_reg == M_RSTART)) ? OP_START :
		(st_reg == M_STOP) ? OP_STOP : ((st_reg == M_DATA) && read_reg) ? OP_RD : OP_WR;
	assign bi.wdata   = (st_reg == M_ADDR) ? (quick_reg ? ADDR_RD : ADDR_WR) :
		(st_reg == M_CMD) ? loc_reg : (st_reg == M_RADDR) ? ADDR_RD : wr_data;
	assign bi.ack_out = !last_byte;
	assign bi.fast    = fast_reg;
	assign bi.scl_s   = scl_s_reg;
	assign bi.sda_s   = sda_s_reg;

	// Open-drain pins: the level driven is always low.
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe   = bi.scl_oe;
	assign sda_oe   = bi.sda_oe;
	assign rd_valid = rd_valid_reg;
	assign rd_data  = rd_data_reg;
	assign done     = done_reg;
	assign nack_err = nack_reg;
	assign tmo_err  = tmo_reg;
	assign busy     = (st_reg != M_IDLE);

	// ========================================================================
	// Free-running spacing counters, both saturating.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gap_reg   <= 12'h000;
			since_reg <= 27'h7ffffff;
		end else begin
			if ((st_reg == M_STOP && bi.done) || bi.tmo) gap_reg <= 12'h000;
			else if (!gap_done) gap_reg <= gap_reg + 12'd1;
			if (cmd_valid && cmd_ready) since_reg <= 27'h0000000;
			else if (since_reg != 27'h7ffffff) since_reg <= since_reg + 27'd1;
		end
	end

	// ========================================================================
	// Packet sequencer.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg       <= M_IDLE;
			issued_reg   <= 1'b0;
			read_reg     <= 1'b0;
			quick_reg    <= 1'b0;
			fast_reg     <= 1'b0;
			split_reg    <= 1'b0;
			err_reg      <= 1'b0;
			last_wr_reg  <= 1'b0;
			loc_reg      <= 8'h00;
			left_reg     <= 4'h0;
			rd_valid_reg <= 1'b0;
			rd_data_reg  <= 8'h00;
			done_reg     <= 1'b0;
			nack_reg     <= 1'b0;
			tmo_reg      <= 1'b0;
		end else begin
			rd_valid_reg <= 1'b0;
			done_reg     <= 1'b0;
			nack_reg     <= 1'b0;
			tmo_reg      <= 1'b0;
			if (bi.req) issued_reg <= 1'b1;
			if (bi.done) issued_reg <= 1'b0;
			if (bi.done && bi.tmo) begin
				tmo_reg   <= 1'b1;
				done_reg  <= 1'b1;
				split_reg <= 1'b0;
				st_reg    <= M_IDLE;
			end else begin
				case (st_reg)
					M_IDLE: if (cmd_valid && cmd_ready) begin
						read_reg    <= cmd_read || cmd_quick;
						quick_reg   <= cmd_quick;
						fast_reg    <= fast_mode;
						last_wr_reg <= !(cmd_read || cmd_quick);
						loc_reg     <= cmd_loc;
						left_reg    <= (cmd_len == 4'd0) ? 4'd1 : cmd_len;
						err_reg     <= 1'b0;
						st_reg      <= M_START;
					end
					M_GAP: if (gap_done) st_reg <= M_START;
					M_START: if (bi.done) st_reg <= M_ADDR;
					M_ADDR: if (bi.done) begin
						err_reg <= !bi.ack_in;
						st_reg  <= !bi.ack_in ? M_STOP : quick_reg ? M_DATA : M_CMD;
					end
					M_CMD: if (bi.done) begin
						err_reg <= !bi.ack_in;
						st_reg  <= !bi.ack_in ? M_STOP : read_reg ? M_RSTART : M_DATA;
					end
					M_RSTART: if (bi.done) st_reg <= M_RADDR;
					M_RADDR: if (bi.done) begin
						err_reg <= !bi.ack_in;
						st_reg  <= bi.ack_in ? M_DATA : M_STOP;
					end
					M_DATA: if (bi.done) begin
						if (read_reg) begin
							rd_valid_reg <= 1'b1;
							rd_data_reg  <= bi.rdata;
							if (!last_byte) loc_reg <= loc_reg + 8'd1;
							left_reg <= left_reg - 4'd1;
							if (last_byte) st_reg <= M_STOP;
						end else if (!bi.ack_in) begin
							err_reg <= 1'b1;
							st_reg  <= M_STOP;
						end else begin
							loc_reg  <= loc_reg + 8'd1;
							left_reg <= left_reg - 4'd1;
							if (!last_byte && fast_reg) split_reg <= 1'b1;
							if (last_byte || fast_reg) st_reg <= M_STOP;
						end
					end
					M_STOP: if (bi.done) begin
						if (split_reg) begin
							split_reg <= 1'b0;
							st_reg    <= M_GAP;
						end else begin
							done_reg <= 1'b1;
							nack_reg <= err_reg;
							st_reg   <= M_IDLE;
						end
					end
					default: st_reg <= M_IDLE;
				endcase
			end
		end
	end

endmodule : gih_host

`default_nettype wire

/* File: testbench/gih_host_properties.sv */
/* Checker for the gauge bus host: spacing, handshake and stretch properties.
   Assumes it is bound to gih_host and sees only that module's ports. */
`timescale 1ns/10ps
`default_nettype none
module gih_host_properties import gih_pkg::*; #(
	parameter int STRETCH_CYC = STRETCH_CYC_DEF,
	parameter int PACE_CYC    = PACE_CYC_DEF,
	parameter int SETTLE_CYC  = SETTLE_CYC_DEF
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Command and write stream
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_read,
	input wire logic fast_mode,
	input wire logic wr_valid,
	input wire logic wr_ready,
	// Status
	input wire logic done,
	input wire logic nack_err,
	input wire logic tmo_err,
	input wire logic busy,
	// Bus pins
	input wire logic scl_i,
	input wire logic scl_oe,
	input wire logic sda_oe
);
	// ====
	// Bus events and takes, decoded from the pins and handshakes.
	logic        oe_q, wr_seen, pkt_wr;
	logic [11:0] free_cnt;
	int          pace_cnt, set_cnt, str_cnt;
	wire logic   take    = cmd_valid && cmd_ready;
	wire logic   wtake   = wr_valid && wr_ready;
	wire logic   start_c = sda_oe && !oe_q && scl_i && !scl_oe;
	wire logic   stop_c  = !sda_oe && oe_q && scl_i && !scl_oe;
	// Spacing counters start saturated so the first command is never flagged.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			oe_q     <= 1'b0;
			wr_seen  <= 1'b0;
			pkt_wr   <= 1'b0;
			free_cnt <= 12'hfff;
			pace_cnt <= PACE_CYC;
			set_cnt  <= SETTLE_CYC;
			str_cnt  <= 0;
		end else begin
			oe_q     <= sda_oe;
			wr_seen  <= take ? !cmd_read : wr_seen;
			pkt_wr   <= start_c ? 1'b0 : (pkt_wr || wtake);
			free_cnt <= stop_c ? 12'h001 : free_cnt + {11'h000, free_cnt != 12'hfff};
			pace_cnt <= take ? 1 : pace_cnt + int'(pace_cnt < PACE_CYC);
			set_cnt  <= (take && !cmd_read) ? 1 : set_cnt + int'(set_cnt < SETTLE_CYC);
			str_cnt  <= (!scl_i && !scl_oe) ? str_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// ====
	// Properties
	bus_free_gap_a: assert property (start_c |-> free_cnt >= TBUF_CYC)
		else $error("start too soon after stop");
	take_pacing_a: assert property (take |-> pace_cnt >= PACE_CYC)
		else $error("commands too close");
	read_settle_a: assert property (take && cmd_read && wr_seen |-> set_cnt >= SETTLE_CYC)
		else $error("read too soon after write");
	fast_one_byte_a: assert property (wtake && fast_mode |-> !pkt_wr)
		else $error("two write bytes in one fast packet");
	stretch_limit_a: assert property (tmo_err |-> str_cnt >= STRETCH_CYC - 4)
		else $error("stretch abandoned early");
	tmo_release_a: assert property (tmo_err |-> !scl_oe && !sda_oe)
		else $error("lines held after timeout");
	busy_start_a: assert property ($rose(busy) |-> $past(take))
		else $error("busy without a command");
	busy_hold_a: assert property (take |=> busy [*8])
		else $error("busy dropped early");
	err_done_a: assert property (nack_err || tmo_err |-> done)
		else $error("error flag without done");
	ready_idle_a: assert property (busy |-> !cmd_ready)
		else $error("ready while busy");
	cover property (done && nack_err);
	cover property (tmo_err);
	cover property (wtake && fast_mode);
endmodule : gih_host_properties
`default_nettype wire

/* File: testbench/gih_gauge_model.sv */
/* Behavioural gauge target on the open-drain bus, with clock stretching.
   Assumes pull-ups: the bench resolves the wires from all pulls. */
`timescale 1ns/10ps
`default_nettype none
module gih_gauge_model (
	// Resolved bus levels
	input  wire logic scl,
	input  wire logic sda,
	// Pulls to low
	output var logic  scl_pull,
	output var logic  sda_pull
);
	// ====
	// State
	logic [7:0] mem [256];
	logic [7:0] ptr, b;
	int         stretch_ns;
	int         low_us;
	logic       asleep;
	event       go;
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		ptr = 8'h00;
		stretch_ns = 0;
		low_us = 0;
		asleep = 1'b0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	// Start restarts the transfer; stop just ends it.
	always @(negedge sda) if (scl === 1'b1) begin
		disable xfer;
		->> go;
	end
	always @(posedge sda) if (scl === 1'b1) disable xfer;
	// after two seconds low: let go, else sleep.
	always begin
		#1000;
		low_us = (scl === 1'b0 || sda === 1'b0) ? low_us + 1 : 0;
		if (low_us == 2000000) begin
			asleep = !(scl_pull || sda_pull);
			disable xfer;
			scl_pull = 1'b0;
			sda_pull = 1'b0;
		end
	end
	task automatic rx(output logic [7:0] v);
		repeat (8) begin
			@(posedge scl);
			v = {v[6:0], sda};
		end
	endtask : rx
	task automatic ack(input logic a);
		@(negedge scl);
		#10 sda_pull = a;
		@(negedge scl);
		scl_pull = (stretch_ns > 0);
		#10 sda_pull = 1'b0;
		#(stretch_ns) scl_pull = 1'b0;
	endtask : ack
	task automatic tx(input logic [7:0] v, output logic a);
		for (int i = 7; i >= 0; i--) begin
			sda_pull = !v[i];
			@(negedge scl);
			#10;
		end
		sda_pull = 1'b0;
		@(posedge scl);
		a = !sda;
		@(negedge scl);
		#10;
	endtask : tx
	always @(go) begin : xfer
		logic [7:0] c;
		logic       a;
		sda_pull = 1'b0;
		rx(b);
		if (b[7:1] == 7'h55) begin
			ack(1'b1);
			if (b[0]) begin
				do begin
					tx(mem[ptr], a);
					ptr = ptr + 8'(a);
				end while (a);
			end else begin
				rx(c);
				ack(c <= 8'h6b);
				if (c <= 8'h6b) begin
					ptr = c;
					forever begin
						rx(c);
						a = (ptr != 8'h20);
						ack(a);
						if (a) mem[ptr] = c;
						ptr = ptr + 8'(a);
					end
				end
			end
		end
	end
endmodule : gih_gauge_model
`default_nettype wire

/* File: testbench/gih_host_tb_top.sv */
/* Self-checking bench for the gauge bus host against a gauge model.
   Assumes short pacing, settle and stretch limits set below. */
`timescale 1ns/10ps
`default_nettype none
module gih_host_tb_top;
	// ====
	// Signals
	logic       core_clk, rst, cmd_valid, cmd_read, cmd_quick, fast_mode, wr_valid;
	logic [7:0] cmd_loc, wr_data, rd_data;
	logic [3:0] cmd_len;
	logic       cmd_ready, wr_ready, rd_valid, done, nack_err, tmo_err, busy;
	logic       scl_oe, sda_oe, m_scl, m_sda, got_n, got_t, scl_lv, sda_lv;
	logic [7:0] rbuf [4];
	int         fail_count, total_checks, rn;
	wire logic  scl_w = ~((scl_oe & ~scl_lv) | m_scl);
	wire logic  sda_w = ~((sda_oe & ~sda_lv) | m_sda);
	gih_host #(.STRETCH_CYC(4000), .PACE_CYC(100), .SETTLE_CYC(200)) i_dut (
		.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_read(cmd_read), .cmd_quick(cmd_quick), .cmd_loc(cmd_loc), .cmd_len(cmd_len),
		.fast_mode(fast_mode), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err),
		.tmo_err(tmo_err), .busy(busy), .scl_i(scl_w), .scl_o(scl_lv), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(sda_lv), .sda_oe(sda_oe));
	gih_gauge_model i_gauge (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	// Runs one command to its done pulse, feeding w0 then w1 and gathering reads.
	task automatic run(input logic rd, input logic qk, input logic [7:0] loc,
		input logic [3:0] len, input logic fs, input logic [7:0] w0, input logic [7:0] w1);
		logic tk, wt, dn;
		rn = 0;
		cmd_read <= rd;
		cmd_quick <= qk;
		cmd_loc <= loc;
		cmd_len <= len;
		fast_mode <= fs;
		wr_data <= w0;
		wr_valid <= 1'b1;
		cmd_valid <= 1'b1;
		for (int n = 0; n < 30000; n++) begin
			@(negedge core_clk);
			tk = cmd_valid && (cmd_ready === 1'b1);
			wt = wr_ready === 1'b1;
			dn = done === 1'b1;
			if (rd_valid === 1'b1 && rn < 4) rbuf[rn++] = rd_data;
			got_n = nack_err;
			got_t = tmo_err;
			@(posedge core_clk);
			if (tk) cmd_valid <= 1'b0;
			if (wt) wr_data <= w1;
			if (dn) return;
		end
		fail_count++;
		complete_run();
	endtask : run
	task automatic t_reset;
		@(negedge core_clk);
		check({3'h0, busy, scl_oe, sda_oe, cmd_ready, done}, 8'h00);
		check(rd_data, 8'h00);
		check({6'h00, scl_lv, sda_lv}, 8'h00);
		@(posedge core_clk);
	endtask : t_reset
	task automatic t_wr_rd;
		run(1'b0, 1'b0, 8'h10, 4'h2, 1'b0, 8'ha5, 8'h5a);
		check({got_t, got_n}, 8'h00);
		run(1'b1, 1'b0, 8'h10, 4'h2, 1'b0, 8'h00, 8'h00);
		check(8'(rn), 8'h02);
		check(rbuf[0], 8'ha5);
		check(rbuf[1], 8'h5a);
	endtask : t_wr_rd
	task automatic t_quick;
		run(1'b1, 1'b1, 8'h00, 4'h1, 1'b0, 8'h00, 8'h00);
		check(8'(rn), 8'h01);
		check(rbuf[0], 8'h5a);
	endtask : t_quick
	task automatic t_fast;
		run(1'b0, 1'b0, 8'h40, 4'h2, 1'b1, 8'hc3, 8'h3c);
		check({got_t, got_n}, 8'h00);
		run(1'b1, 1'b0, 8'h40, 4'h2, 1'b1, 8'h00, 8'h00);
		check(rbuf[0], 8'hc3);
		check(rbuf[1], 8'h3c);
	endtask : t_fast
	task automatic t_refuse;
		logic [7:0] locs [3] = '{8'h6b, 8'h6c, 8'h20};
		for (int i = 0; i < 3; i++) begin
			run(1'b0, 1'b0, locs[i], 4'h1, 1'b1, 8'h99, 8'h99);
			check({7'h00, got_n}, {7'h00, i != 0});
		end
	endtask : t_refuse
	task automatic t_stretch;
		i_gauge.stretch_ns = 50000;
		run(1'b0, 1'b0, 8'h50, 4'h1, 1'b1, 8'h77, 8'h77);
		check({got_t, got_n}, 8'h00);
		i_gauge.stretch_ns = 150000;
		run(1'b0, 1'b0, 8'h51, 4'h1, 1'b1, 8'h77, 8'h77);
		check({7'h00, got_t}, 8'h01);
		i_gauge.stretch_ns = 0;
	endtask : t_stretch
	initial begin
		rst = 1'b1;
		{cmd_valid, cmd_read, cmd_quick, fast_mode, wr_valid} = 5'h00;
		{cmd_loc, wr_data, cmd_len} = 20'h00000;
		fail_count = 0;
		total_checks = 0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_wr_rd();
		t_quick();
		t_fast();
		t_refuse();
		t_stretch();
		complete_run();
	end
endmodule : gih_host_tb_top
bind gih_host gih_host_properties #(.STRETCH_CYC(STRETCH_CYC), .PACE_CYC(PACE_CYC),
	.SETTLE_CYC(SETTLE_CYC)) i_props (.core_clk(core_clk), .rst(rst),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
	.fast_mode(fast_mode), .wr_valid(wr_valid), .wr_ready(wr_ready), .done(done),
	.nack_err(nack_err), .tmo_err(tmo_err), .busy(busy), .scl_i(scl_i),
	.scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire
